// ### hdl/cke_top.sv
// How it works
// - Hex or decimal mode comes from switch
// - Centre polarity: zero output, signs alternate
// - Centre keeps entry; applies on plus/minus
// - 24 keys; buzz except increment/decrement
// - Cursor moves; buzz only when it moves
// - Inc/dec step cursor digit, output at once
// - Letter digits only in hex mode
// - Out-of-range entry rejected, flagged bad
// - Decimal point only in decimal mode
// - Clear discards entry and blanks display
// - Typed value reaches output only on enter
// - Shift mode: inc doubles, dec halves
// - Shift mode lights all four points
// - Shift key ignored outside hex mode
// - Overload sense lights current limit
// - Low battery sense lights battery indicator
// - Bad message about 3 s, then revert
// - Doubling zero gives one
// - Hex code 000..FFF linear to output
// - Limits: FFF in hex, 1.2/12 decimal
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cke_top #(
  parameter int unsigned BAD_MSG_CYC = cke_pkg::BAD_MSG_CYC,
  parameter int unsigned BLINK_CYC   = cke_pkg::BLINK_CYC,
  parameter int unsigned BEEP_CYC    = cke_pkg::BEEP_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cke_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          keyValid,
  input  wire logic [cke_pkg::KEY_W-1:0]     keyCode,
  input  wire logic                          hexModeSw,
  input  wire logic                          rangeHighSw,
  input  wire logic [1:0]                    polaritySw,
  input  wire logic                          overloadSense,
  input  wire logic                          batteryLowSense,
  output logic      [cke_pkg::VAL_W-1:0]     outCode,
  output logic                               outNegative,
  output logic      [cke_pkg::VAL_W-1:0]     dispValue,
  output logic                               dispBlank,
  output logic      [3:0]                    dispPoints,
  output logic                               signPlus,
  output logic                               signMinus,
  output logic                               invalidEntryMessage,
  output logic                               currentLimitInd,
  output logic                               lowBatteryInd,
  output logic                               buzzer
);

  localparam int unsigned CW = cke_pkg::CNT_W;
  localparam int unsigned VW = cke_pkg::VAL_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Carry ripples from the cursor digit upward; a carry out of the top means wrap
  function automatic logic [VW:0] stepDigit(input logic [VW-1:0] v, input logic [2:0] pos,
                                            input logic up, input logic [3:0] maxNib);
    logic [VW-1:0] r;
    logic          c;
    logic [3:0]    n;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 5; i++) begin
      n = r[4*i+:4];
      if (i >= int'(pos) && c) begin
        if (up) begin
          if (n == maxNib) begin
            n = 4'h0;
          end else begin
            n = n + 4'h1;
            c = 1'b0;
          end
        end else begin
          if (n == 4'h0) begin
            n = maxNib;
          end else begin
            n = n - 4'h1;
            c = 1'b0;
          end
        end
      end
      r[4*i+:4] = n;
    end
    return {c, r};
  endfunction

  // Pads missing fraction digits with zeros so the value counts in scale units
  function automatic logic [VW:0] alignDec(input logic [VW-1:0] v, input logic [2:0] frac,
                                           input logic [2:0] expFrac);
    logic [VW-1:0] r;
    logic          bad;
    logic [2:0]    diff;
    r    = v;
    bad  = frac > expFrac;
    diff = expFrac - frac;
    for (int i = 0; i < 4; i++) begin
      if (!bad && i < int'(diff)) begin
        bad = r[VW-1-:4] != 4'h0;
        r   = {r[VW-5:0], 4'h0};
      end
    end
    if (r > cke_pkg::LIMIT_DEC) begin
      bad = 1'b1;
    end
    return {bad, r};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [VW-1:0]  entry_q, entry_d, committed_q, committed_d;
  logic [2:0]     digits_q, digits_d, frac_q, frac_d, cursor_q, cursor_d;
  logic           pointSeen_q, pointSeen_d, overflow_q, overflow_d;
  logic           entryActive_q, entryActive_d, blank_q, blank_d;
  logic           shift_q, shift_d, hexMode_q, hexMode_d;
  logic [CW-1:0]  badCnt_q, badCnt_d, beepCnt_q, beepCnt_d, blinkCnt_q, blinkCnt_d;
  logic           blinkPhase_q, blinkPhase_d;
  logic [VW-1:0]  outCode_d, dispValue_d;
  logic           outNegative_d, dispBlank_d, signPlus_d, signMinus_d;
  logic           invalidMsg_d, currentLimit_d, lowBattery_d, buzzer_d;
  logic [3:0]     dispPoints_d;
  logic           keypadEn_q, keypadEn_d, swKeyValid_q, swKeyValid_d;
  logic [cke_pkg::KEY_W-1:0] swKeyCode_q, swKeyCode_d;
  logic [31:0]    prdata_d;
  logic           pready_d, pslverr_d;

  logic                      keyHit, isDigit, zeroSel;
  logic [cke_pkg::KEY_W-1:0] key;
  logic [VW:0]               res;
  logic [VW-1:0]             limit, baseEntry;
  logic [3:0]                maxNib;
  logic [2:0]                cursorMax, expFrac, baseDigits, baseFrac;
  logic                      basePoint, baseOvf, buzz;

  // ****************************************************************
  // Keypad, entry and output logic
  // ****************************************************************
  always_comb begin
    entry_d       = entry_q;
    committed_d   = committed_q;
    digits_d      = digits_q;
    frac_d        = frac_q;
    cursor_d      = cursor_q;
    pointSeen_d   = pointSeen_q;
    overflow_d    = overflow_q;
    entryActive_d = entryActive_q;
    blank_d       = blank_q;
    shift_d       = shift_q;
    hexMode_d     = hexModeSw;
    buzz          = 1'b0;
    res           = '0;
    keyHit        = (keyValid && keypadEn_q) || swKeyValid_q;
    key           = swKeyValid_q ? swKeyCode_q : keyCode;
    limit         = hexMode_q ? cke_pkg::LIMIT_HEX : cke_pkg::LIMIT_DEC;
    maxNib        = hexMode_q ? cke_pkg::DIGIT_MAX_HEX : cke_pkg::DIGIT_MAX_DEC;
    cursorMax     = hexMode_q ? cke_pkg::CURSOR_MAX_HEX : cke_pkg::CURSOR_MAX_DEC;
    expFrac       = rangeHighSw ? cke_pkg::FRAC_HIGH : cke_pkg::FRAC_LOW;
    isDigit       = key <= cke_pkg::KEY_NINE || (hexMode_q && key <= cke_pkg::KEY_F);
    // A key after a commit starts a fresh entry
    baseEntry     = entryActive_q ? entry_q : '0;
    baseDigits    = entryActive_q ? digits_q : 3'h0;
    baseFrac      = entryActive_q ? frac_q : 3'h0;
    basePoint     = entryActive_q && pointSeen_q;
    baseOvf       = entryActive_q && overflow_q;
    badCnt_d      = (badCnt_q != '0) ? badCnt_q - CW'(1) : badCnt_q;
    beepCnt_d     = (beepCnt_q != '0) ? beepCnt_q - CW'(1) : beepCnt_q;

    if (hexModeSw != hexMode_q) begin
      // Codes of one mode mean nothing in the other, so start over
      entryActive_d = 1'b0;
      committed_d   = '0;
      cursor_d      = 3'h0;
      shift_d       = 1'b0;
      blank_d       = 1'b0;
    end else if (keyHit) begin
      if (isDigit) begin
        buzz          = 1'b1;
        entryActive_d = 1'b1;
        blank_d       = 1'b0;
        pointSeen_d   = basePoint;
        if (baseDigits == cke_pkg::MAX_DIGITS) begin
          entry_d    = baseEntry;
          digits_d   = baseDigits;
          frac_d     = baseFrac;
          overflow_d = 1'b1;
        end else begin
          entry_d    = {baseEntry[VW-5:0], key[3:0]};
          digits_d   = baseDigits + 3'h1;
          frac_d     = basePoint ? baseFrac + 3'h1 : baseFrac;
          overflow_d = baseOvf;
        end
      end else begin
        unique case (key)
          cke_pkg::KEY_POINT: begin
            if (!hexMode_q && !basePoint) begin
              buzz          = 1'b1;
              entryActive_d = 1'b1;
              blank_d       = 1'b0;
              pointSeen_d   = 1'b1;
              entry_d       = baseEntry;
              digits_d      = baseDigits;
              frac_d        = 3'h0;
              overflow_d    = baseOvf;
            end
          end
          cke_pkg::KEY_CLEAR: begin
            buzz          = 1'b1;
            entryActive_d = 1'b0;
            blank_d       = 1'b1;
          end
          cke_pkg::KEY_ENTER: begin
            buzz = 1'b1;
            if (entryActive_q) begin
              res = hexMode_q ? {overflow_q || entry_q > cke_pkg::LIMIT_HEX, entry_q}
                              : alignDec(entry_q, frac_q, expFrac);
              res[VW] = res[VW] || overflow_q;
              if (res[VW]) begin
                badCnt_d = CW'(BAD_MSG_CYC);
              end else begin
                committed_d = res[VW-1:0];
              end
              entryActive_d = 1'b0;
              blank_d       = 1'b0;
            end
          end
          cke_pkg::KEY_LEFT: begin
            if (cursor_q < cursorMax) begin
              cursor_d = cursor_q + 3'h1;
              buzz     = 1'b1;
            end
          end
          cke_pkg::KEY_RIGHT: begin
            if (cursor_q != 3'h0) begin
              cursor_d = cursor_q - 3'h1;
              buzz     = 1'b1;
            end
          end
          cke_pkg::KEY_INC, cke_pkg::KEY_DEC: begin
            if (shift_q && hexMode_q) begin
              if (key == cke_pkg::KEY_INC) begin
                res = (committed_q == '0) ? {1'b0, cke_pkg::VAL_ONE}
                                          : {1'b0, committed_q[VW-2:0], 1'b0};
              end else begin
                res = {2'b00, committed_q[VW-1:1]};
              end
            end else begin
              res = stepDigit(committed_q, cursor_q, key == cke_pkg::KEY_INC, maxNib);
            end
            if (!res[VW] && res[VW-1:0] <= limit) begin
              committed_d = res[VW-1:0];
            end
            entryActive_d = 1'b0;
            blank_d       = 1'b0;
          end
          cke_pkg::KEY_SHIFT: begin
            if (hexMode_q) begin
              shift_d = !shift_q;
              buzz    = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (buzz) begin
      beepCnt_d = CW'(BEEP_CYC);
    end

    if (blinkCnt_q == CW'(BLINK_CYC - 1)) begin
      blinkCnt_d   = '0;
      blinkPhase_d = !blinkPhase_q;
    end else begin
      blinkCnt_d   = blinkCnt_q + CW'(1);
      blinkPhase_d = blinkPhase_q;
    end

    // Output follows the committed code; the centre position forces zero
    zeroSel       = polaritySw != cke_pkg::POL_PLUS && polaritySw != cke_pkg::POL_MINUS;
    outCode_d     = zeroSel ? '0 : committed_d;
    outNegative_d = polaritySw == cke_pkg::POL_MINUS;
    signPlus_d    = zeroSel ? blinkPhase_d : !outNegative_d;
    signMinus_d   = zeroSel ? !blinkPhase_d : outNegative_d;
    invalidMsg_d  = badCnt_d != '0;
    dispBlank_d   = blank_d;
    dispValue_d   = (blank_d || invalidMsg_d) ? '0
                  : (entryActive_d ? entry_d : committed_d);
    if (shift_d && hexMode_d) begin
      dispPoints_d = cke_pkg::DP_ALL;
    end else if (hexMode_d || blank_d || invalidMsg_d) begin
      dispPoints_d = 4'h0;
    end else if (entryActive_d) begin
      dispPoints_d = (pointSeen_d && frac_d != 3'h0) ? 4'(1 << (frac_d - 3'h1)) : 4'h0;
    end else begin
      dispPoints_d = 4'(1 << (expFrac - 3'h1));
    end
    currentLimit_d = overloadSense;
    lowBattery_d   = batteryLowSense;
    buzzer_d       = beepCnt_d != '0;
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_comb begin
    prdata_d     = prdata;
    pready_d     = psel && !penable;
    pslverr_d    = 1'b0;
    keypadEn_d   = keypadEn_q;
    swKeyValid_d = 1'b0;
    swKeyCode_d  = swKeyCode_q;
    if (psel && !penable) begin
      prdata_d = '0;
      unique case (paddr)
        cke_pkg::REG_CTRL:   prdata_d[cke_pkg::CTRL_KEYPAD_EN] = keypadEn_q;
        cke_pkg::REG_KEY:    prdata_d = '0;
        cke_pkg::REG_STATUS: begin
          prdata_d[cke_pkg::ST_HEX]        = hexMode_q;
          prdata_d[cke_pkg::ST_SHIFT]      = shift_q;
          prdata_d[cke_pkg::ST_BAD]        = invalidEntryMessage;
          prdata_d[cke_pkg::ST_ENTRY]      = entryActive_q;
          prdata_d[cke_pkg::ST_CLIMIT]     = currentLimitInd;
          prdata_d[cke_pkg::ST_LOWBAT]     = lowBatteryInd;
          prdata_d[cke_pkg::ST_ZERO]       = signPlus != !outNegative || signMinus != outNegative;
          prdata_d[cke_pkg::ST_CURSOR+:3]  = cursor_q;
        end
        cke_pkg::REG_OUT:    prdata_d[VW-1:0] = committed_q;
        cke_pkg::REG_ENTRY:  prdata_d[VW-1:0] = entry_q;
        default:             pslverr_d = 1'b1;
      endcase
    end
    // Writes land at the completing edge of the access phase
    if (psel && penable && pready && pwrite) begin
      if (paddr == cke_pkg::REG_CTRL) begin
        keypadEn_d = pwdata[cke_pkg::CTRL_KEYPAD_EN];
      end else if (paddr == cke_pkg::REG_KEY) begin
        swKeyValid_d = 1'b1;
        swKeyCode_d  = pwdata[cke_pkg::KEY_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      entry_q             <= '0;
      committed_q         <= '0;
      digits_q            <= 3'h0;
      frac_q              <= 3'h0;
      cursor_q            <= 3'h0;
      pointSeen_q         <= 1'b0;
      overflow_q          <= 1'b0;
      entryActive_q       <= 1'b0;
      blank_q             <= 1'b0;
      shift_q             <= 1'b0;
      hexMode_q           <= 1'b0;
      badCnt_q            <= '0;
      beepCnt_q           <= '0;
      blinkCnt_q          <= '0;
      blinkPhase_q        <= 1'b0;
      outCode             <= '0;
      outNegative         <= 1'b0;
      dispValue           <= '0;
      dispBlank           <= 1'b0;
      dispPoints          <= 4'h0;
      signPlus            <= 1'b0;
      signMinus           <= 1'b0;
      invalidEntryMessage <= 1'b0;
      currentLimitInd     <= 1'b0;
      lowBatteryInd       <= 1'b0;
      buzzer              <= 1'b0;
      keypadEn_q          <= cke_pkg::CTRL_RESET;
      swKeyValid_q        <= 1'b0;
      swKeyCode_q         <= '0;
      prdata              <= '0;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end else begin
      entry_q             <= entry_d;
      committed_q         <= committed_d;
      digits_q            <= digits_d;
      frac_q              <= frac_d;
      cursor_q            <= cursor_d;
      pointSeen_q         <= pointSeen_d;
      overflow_q          <= overflow_d;
      entryActive_q       <= entryActive_d;
      blank_q             <= blank_d;
      shift_q             <= shift_d && hexMode_d;
      hexMode_q           <= hexMode_d;
      badCnt_q            <= badCnt_d;
      beepCnt_q           <= beepCnt_d;
      blinkCnt_q          <= blinkCnt_d;
      blinkPhase_q        <= blinkPhase_d;
      outCode             <= outCode_d;
      outNegative         <= outNegative_d;
      dispValue           <= dispValue_d;
      dispBlank           <= dispBlank_d;
      dispPoints          <= dispPoints_d;
      signPlus            <= signPlus_d;
      signMinus           <= signMinus_d;
      invalidEntryMessage <= invalidMsg_d;
      currentLimitInd     <= currentLimit_d;
      lowBatteryInd       <= lowBattery_d;
      buzzer              <= buzzer_d;
      keypadEn_q          <= keypadEn_d;
      swKeyValid_q        <= swKeyValid_d;
      swKeyCode_q         <= swKeyCode_d;
      prdata              <= prdata_d;
      pready              <= pready_d;
      pslverr             <= pslverr_d;
    end
  end

endmodule

// ### hdl/cke_pkg.sv
package cke_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned BAD_MSG_MS   = 3000;
  localparam int unsigned BLINK_MS     = 500;
  localparam int unsigned BEEP_MS      = 50;
  localparam int unsigned BAD_MSG_CYC  = CLK_HZ / 1000 * BAD_MSG_MS;
  localparam int unsigned BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned BEEP_CYC     = CLK_HZ / 1000 * BEEP_MS;
  localparam int unsigned CNT_W        = 27;

  // ****************************************************************
  // Keys, switches and value limits
  // ****************************************************************
  localparam int unsigned KEY_W        = 5;
  localparam logic [4:0]  KEY_NINE     = 5'h09;
  localparam logic [4:0]  KEY_F        = 5'h0F;
  localparam logic [4:0]  KEY_POINT    = 5'h10;
  localparam logic [4:0]  KEY_CLEAR    = 5'h11;
  localparam logic [4:0]  KEY_ENTER    = 5'h12;
  localparam logic [4:0]  KEY_LEFT     = 5'h13;
  localparam logic [4:0]  KEY_RIGHT    = 5'h14;
  localparam logic [4:0]  KEY_INC      = 5'h15;
  localparam logic [4:0]  KEY_DEC      = 5'h16;
  localparam logic [4:0]  KEY_SHIFT    = 5'h17;
  localparam logic [1:0]  POL_PLUS     = 2'h1;
  localparam logic [1:0]  POL_MINUS    = 2'h2;
  localparam int unsigned VAL_W        = 20;
  localparam logic [19:0] LIMIT_DEC    = 20'h12000;
  localparam logic [19:0] LIMIT_HEX    = 20'h00FFF;
  localparam logic [19:0] VAL_ONE      = 20'h00001;
  localparam logic [3:0]  DIGIT_MAX_DEC = 4'h9;
  localparam logic [3:0]  DIGIT_MAX_HEX = 4'hF;
  localparam logic [2:0]  CURSOR_MAX_DEC = 3'h4;
  localparam logic [2:0]  CURSOR_MAX_HEX = 3'h2;
  localparam logic [2:0]  FRAC_HIGH    = 3'h3;
  localparam logic [2:0]  FRAC_LOW     = 3'h4;
  localparam logic [2:0]  MAX_DIGITS   = 3'h5;
  localparam logic [3:0]  DP_ALL       = 4'hF;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_KEY      = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_OUT      = 8'h0C;
  localparam logic [7:0]  REG_ENTRY    = 8'h10;
  localparam int unsigned CTRL_KEYPAD_EN = 0;
  localparam logic        CTRL_RESET   = 1'b1;
  localparam int unsigned ST_HEX       = 0;
  localparam int unsigned ST_SHIFT     = 1;
  localparam int unsigned ST_BAD       = 2;
  localparam int unsigned ST_ENTRY     = 3;
  localparam int unsigned ST_CLIMIT    = 4;
  localparam int unsigned ST_LOWBAT    = 5;
  localparam int unsigned ST_ZERO      = 6;
  localparam int unsigned ST_CURSOR    = 8;

endpackage

// ### test/cke_operator.sv
`timescale 1ns/1ps
module cke_operator (
  input  wire logic                      core_clk,
  output logic                           keyValid,
  output logic [cke_pkg::KEY_W-1:0]      keyCode
);
  // ****************************************************************
  // Operator at the keypad
  // ****************************************************************
  initial begin
    keyValid = 1'b0;
    keyCode  = 5'h1F;
  end
  // One press is one pulse; the code lines change afterwards, so a late read shows junk
  task automatic press(input logic [4:0] code);
    @(posedge core_clk);
    keyValid <= 1'b1;
    keyCode  <= code;
    @(posedge core_clk);
    keyValid <= 1'b0;
    keyCode  <= ~code;
  endtask
endmodule

// ### test/cke_sva.sv
`timescale 1ns/1ps
module cke_sva #(
  parameter int unsigned BAD_MSG_CYC = 50
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [1:0]  polaritySw,
  input wire logic [19:0] outCode,
  input wire logic        overloadSense,
  input wire logic        currentLimitInd,
  input wire logic        buzzer,
  input wire logic        keyValid,
  input wire logic [4:0]  keyCode,
  input wire logic        hexModeSw,
  input wire logic [3:0]  dispPoints,
  input wire logic        invalidEntryMessage
);
  // ****************************************************************
  // Port checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] badCnt_d, badCnt_q;
  always_comb badCnt_d = invalidEntryMessage ? badCnt_q + 32'h1 : 32'h0;
  always_ff @(posedge core_clk) badCnt_q <= reset_n ? badCnt_d : 32'h0;
  sequence centreSel; polaritySw == 2'h0 || polaritySw == 2'h3; endsequence
  sequence beepHeld; buzzer [*4]; endsequence
  zero_out_a: assert property (centreSel |=> outCode == 20'h0)
    else $error("centre polarity left a nonzero output");
  beep_len_a: assert property ($rose(buzzer) |-> beepHeld)
    else $error("beep shorter than four cycles");
  step_quiet_a: assert property (keyValid && !buzzer && (keyCode == cke_pkg::KEY_INC ||
    keyCode == cke_pkg::KEY_DEC) |=> !buzzer) else $error("step key beeped");
  climit_a: assert property (reset_n && overloadSense |=> currentLimitInd)
    else $error("current limit not shown");
  hex_limit_a: assert property (hexModeSw [*4] |-> outCode <= cke_pkg::LIMIT_HEX)
    else $error("hex output above full scale");
  dec_limit_a: assert property (!hexModeSw [*4] |-> outCode <= cke_pkg::LIMIT_DEC)
    else $error("decimal output above full scale");
  no_shift_a: assert property (!hexModeSw [*4] |-> dispPoints != cke_pkg::DP_ALL)
    else $error("shift indicator in decimal mode");
  bad_len_a: assert property (reset_n && $fell(invalidEntryMessage) |->
    badCnt_q == BAD_MSG_CYC) else $error("bad entry message length wrong");
endmodule
bind cke_top cke_sva #(.BAD_MSG_CYC(BAD_MSG_CYC)) i_sva (.core_clk(core_clk),
  .reset_n(reset_n), .polaritySw(polaritySw), .outCode(outCode), .buzzer(buzzer),
  .overloadSense(overloadSense), .currentLimitInd(currentLimitInd), .keyValid(keyValid),
  .keyCode(keyCode), .hexModeSw(hexModeSw), .dispPoints(dispPoints),
  .invalidEntryMessage(invalidEntryMessage));

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin numErrors++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
  typedef struct packed {
    logic            hex;
    logic            rng;
    logic [5:0][4:0] keys;
    logic [19:0]     out;
    logic            bad;
  } cke_row_t;
  localparam logic [4:0] kP = 5'h10, kC = 5'h11, kE = 5'h12, kN = 5'h1F;
  logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, keyValid, err;
  logic        hexModeSw, rangeHighSw, overloadSense, batteryLowSense, buzzer;
  logic        invalidEntryMessage, currentLimitInd, lowBatteryInd;
  logic        outNegative, dispBlank, signPlus, signMinus;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  keyCode;
  logic [1:0]  polaritySw;
  logic [19:0] outCode, dispValue;
  logic [3:0]  dispPoints;
  int          numErrors, comparisons, cycles;
  cke_row_t    rows [8] = '{
    '{1'b0, 1'b0, {5'h01, kP, 5'h02, kE, kN, kN}, 20'h12000, 1'b0},
    '{1'b0, 1'b1, {5'h09, kP, 5'h03, 5'h05, 5'h04, kE}, 20'h09354, 1'b0},
    '{1'b0, 1'b1, {5'h01, 5'h03, kE, kN, kN, kN}, 20'h09354, 1'b1},
    '{1'b0, 1'b1, {5'h0A, 5'h05, kE, kN, kN, kN}, 20'h05000, 1'b0},
    '{1'b0, 1'b1, {5'h07, kC, kE, kN, kN, kN}, 20'h05000, 1'b0},
    '{1'b1, 1'b1, {5'h01, 5'h0F, 5'h0A, kE, kN, kN}, 20'h001FA, 1'b0},
    '{1'b1, 1'b1, {5'h01, 5'h00, 5'h00, 5'h00, kE, kN}, 20'h001FA, 1'b1},
    '{1'b1, 1'b1, {kP, 5'h02, kE, kN, kN, kN}, 20'h00002, 1'b0}};
  cke_top #(.BAD_MSG_CYC(50), .BLINK_CYC(8), .BEEP_CYC(4)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .keyValid(keyValid),
    .keyCode(keyCode), .hexModeSw(hexModeSw), .rangeHighSw(rangeHighSw),
    .polaritySw(polaritySw), .overloadSense(overloadSense), .batteryLowSense(batteryLowSense),
    .outCode(outCode), .outNegative(outNegative), .dispValue(dispValue),
    .dispBlank(dispBlank), .signPlus(signPlus), .dispPoints(dispPoints),
    .signMinus(signMinus), .invalidEntryMessage(invalidEntryMessage),
    .currentLimitInd(currentLimitInd), .lowBatteryInd(lowBatteryInd), .buzzer(buzzer));
  cke_operator i_op (.core_clk(core_clk), .keyValid(keyValid), .keyCode(keyCode));
  // ****************************************************************
  // Drivers
  // ****************************************************************
  always #20 core_clk = ~core_clk;
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Spacing outlasts the beep so each press is judged alone
  task automatic key(input logic [4:0] c);
    i_op.press(c);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic finalReport();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      finalReport();
    end
  end
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hexModeSw, rangeHighSw, overloadSense, batteryLowSense} = '0;
    polaritySw = cke_pkg::POL_PLUS;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[r]) begin
      hexModeSw <= rows[r].hex;
      rangeHighSw <= rows[r].rng;
      repeat (3) @(posedge core_clk);
      for (int i = 5; i >= 0; i--) begin
        if (rows[r].keys[i] != kN) key(rows[r].keys[i]);
      end
      `CHK(outCode, rows[r].out)
      `CHK(invalidEntryMessage, rows[r].bad)
      `CHK(dispBlank, rows[r].keys[4] == kC)
      repeat (60) @(posedge core_clk);
    end
    polaritySw <= 2'h0;
    settle();
    `CHK(outCode, 20'h0)
    `CHK(dispValue, 20'h00002)
    rd[1:0] = {signPlus, signMinus};
    repeat (5) @(posedge core_clk);
    settle();
    `CHK({signPlus, signMinus, rd[0]}, {~rd[1:0], ~rd[1]})
    @(posedge core_clk);
    polaritySw <= cke_pkg::POL_MINUS;
    settle();
    `CHK(outCode, 20'h00002)
    `CHK(outNegative, 1'b1)
    key(cke_pkg::KEY_INC);
    `CHK(outCode, 20'h00003)
    key(cke_pkg::KEY_LEFT);
    key(cke_pkg::KEY_INC);
    `CHK(outCode, 20'h00013)
    key(cke_pkg::KEY_LEFT);
    i_op.press(cke_pkg::KEY_LEFT);
    @(negedge core_clk);
    `CHK(buzzer, 1'b0)
    key(cke_pkg::KEY_SHIFT);
    `CHK(dispPoints, cke_pkg::DP_ALL)
    key(cke_pkg::KEY_INC);
    `CHK(outCode, 20'h00026)
    key(cke_pkg::KEY_DEC);
    `CHK(outCode, 20'h00013)
    @(posedge core_clk);
    hexModeSw <= 1'b0;
    settle();
    key(cke_pkg::KEY_SHIFT);
    `CHK(dispPoints == cke_pkg::DP_ALL, 1'b0)
    @(posedge core_clk);
    {hexModeSw, overloadSense, batteryLowSense} <= 3'b111;
    settle();
    `CHK({currentLimitInd, lowBatteryInd}, 2'b11)
    key(cke_pkg::KEY_SHIFT);
    key(cke_pkg::KEY_INC);
    `CHK(outCode, 20'h00001)
    key(cke_pkg::KEY_LEFT);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    settle();
    `CHK(outCode, 20'h0)
    apb(1'b0, cke_pkg::REG_STATUS, 32'h0);
    `CHK(rd & 32'h0000070A, 32'h0)
    apb(1'b1, cke_pkg::REG_KEY, 32'h00000005);
    apb(1'b0, cke_pkg::REG_OUT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, cke_pkg::REG_KEY, {27'h0, cke_pkg::KEY_ENTER});
    settle();
    apb(1'b0, cke_pkg::REG_OUT, 32'h0);
    `CHK(rd, 32'h00000005)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    finalReport();
  end
endmodule
